// file: pkg/ssp_pkg.sv
package ssp_pkg;

  // ****************************************
  // Clocking and timing
  // ****************************************
  localparam int SYS_PERIOD_NS = 50;
  localparam int SYS_FREQ_HZ   = 20_000_000;
  localparam int SCLK_MAX_HZ   = 5_000_000;
  localparam int CS_GAP_NS     = 150;
  // Least times round up
  localparam int SCLK_HALF_CYC =
    (SYS_FREQ_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int CS_GAP_CYC    =
    (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int CNT_W         = 2;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SCLK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(CS_GAP_CYC - 1);

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int BYTE_W        = 8;
  localparam int ADDR_W        = 6;
  localparam int CMD_RW_BIT    = 7;
  localparam int CMD_BURST_BIT = 6;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_FORMAT = 6'h31;
  localparam int                FMT_WIRE_BIT      = 6;
  localparam logic [BYTE_W-1:0] FMT_RESET         = 8'h00;

  // ****************************************
  // Controller register map
  // ****************************************
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  localparam logic [REG_AW-1:0] HREG_CTRL   = 4'h0;
  localparam logic [REG_AW-1:0] HREG_DATA   = 4'h4;
  localparam logic [REG_AW-1:0] HREG_STATUS = 4'h8;
  localparam logic [REG_AW-1:0] HREG_RX     = 4'hC;
  localparam int CTL_START    = 0;
  localparam int CTL_READ     = 1;
  localparam int CTL_BURST    = 2;
  localparam int CTL_3W       = 3;
  localparam int CTL_NB_LSB   = 4;
  localparam int CTL_ADDR_LSB = 8;
  localparam int STS_BUSY     = 0;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_LEAD = 3'h1,
    HS_LOW  = 3'h3,
    HS_HIGH = 3'h2,
    HS_TAIL = 3'h6,
    HS_GAP  = 3'h4
  } ssp_hst_t;

endpackage : ssp_pkg

// file: pkg/ssp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic mosi_oe;
  logic sdo;
  logic sdo_oe;
  logic sdio_d;
  logic sdio_oe;
  logic sdio;
  logic sdo_line;

  // Shared data line; idles high like the recommended pull
  assign sdio     = mosi_oe ? mosi : (sdio_oe ? sdio_d : 1'h1);
  assign sdo_line = sdo_oe ? sdo : 1'h1;

  modport dev  (input cs_n, sclk, sdio,
                output sdo, sdo_oe, sdio_d, sdio_oe);
  modport host (output cs_n, sclk, mosi, mosi_oe,
                input sdo_line, sdio);
endinterface : ssp_link_if
`default_nettype wire

// file: src/ssp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ssp_sync
`default_nettype wire

// file: src/ssp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
  input  wire logic                       SYS_CLK,
  input  wire logic                       SRST,
  input  wire logic                       CE,
  input  wire logic [ssp_pkg::REG_AW-1:0] ADDR,
  input  wire logic [ssp_pkg::REG_DW-1:0] WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output var  logic [ssp_pkg::REG_DW-1:0] RDATA,
  output var  logic                       BUSY,
  ssp_link_if.host                        link
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ssp_pkg::ssp_hst_t                st;
    logic [ssp_pkg::CNT_W-1:0]        cnt;
    logic [2:0]                       bitn;
    logic [2:0]                       byten;
    logic [1:0]                       nlast;
    logic                             rd;
    logic                             burst;
    logic                             three;
    logic [ssp_pkg::ADDR_W-1:0]       raddr;
    logic [ssp_pkg::BYTE_W-1:0]       tx;
    logic [ssp_pkg::BYTE_W-2:0]       rx;
    logic [ssp_pkg::REG_DW-1:0]       data;
    logic [ssp_pkg::REG_DW-1:0]       rxw;
    logic [ssp_pkg::REG_DW-1:0]       rdata;
    logic                             busy;
    logic                             cs_n;
    logic                             sclk;
    logic                             mosi;
    logic                             mosi_oe;
  } ssp_host_state_t;

  // Link idles deselected, clock high, data driven high
  localparam ssp_host_state_t RST = '{
    st:      ssp_pkg::HS_IDLE,
    cnt:     '0,
    bitn:    '0,
    byten:   '0,
    nlast:   '0,
    rd:      1'h0,
    burst:   1'h0,
    three:   1'h0,
    raddr:   '0,
    tx:      '0,
    rx:      '0,
    data:    '0,
    rxw:     '0,
    rdata:   '0,
    busy:    1'h0,
    cs_n:    1'h1,
    sclk:    1'h1,
    mosi:    1'h1,
    mosi_oe: 1'h1
  };

  ssp_host_state_t s_reg;
  ssp_host_state_t s_next;
  logic [1:0]      miso_s;
  logic            miso_bit;
  logic [ssp_pkg::BYTE_W-1:0] rx_byte;
  logic [ssp_pkg::BYTE_W-1:0] nxt_byte;
  logic            ctrl_go;

  // ****************************************
  // Input synchroniser
  // ****************************************
  ssp_sync #(
    .W (2)
  ) u_sync (
    .clk (SYS_CLK),
    .ce  (CE),
    .d   ({link.sdo_line, link.sdio}),
    .q   (miso_s)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next   = s_reg;
    // Sampled late in the high half so the sync delay is covered
    miso_bit = s_reg.three ? miso_s[0] : miso_s[1];
    rx_byte  = {s_reg.rx, miso_bit};
    nxt_byte = s_reg.data[{s_reg.byten[1:0], 3'h0} +: ssp_pkg::BYTE_W];
    ctrl_go  = WR && (ADDR == ssp_pkg::HREG_CTRL)
               && WDATA[ssp_pkg::CTL_START] && !s_reg.busy;

    s_next.rdata = '0;
    if (RD) begin
      case (ADDR)
        ssp_pkg::HREG_CTRL: begin
          s_next.rdata = '0;
          s_next.rdata[ssp_pkg::CTL_READ]  = s_reg.rd;
          s_next.rdata[ssp_pkg::CTL_BURST] = s_reg.burst;
          s_next.rdata[ssp_pkg::CTL_3W]    = s_reg.three;
          s_next.rdata[ssp_pkg::CTL_NB_LSB +: 2] = s_reg.nlast;
          s_next.rdata[ssp_pkg::CTL_ADDR_LSB +: ssp_pkg::ADDR_W] =
            s_reg.raddr;
        end
        ssp_pkg::HREG_DATA: begin
          s_next.rdata = s_reg.data;
        end
        ssp_pkg::HREG_STATUS: begin
          s_next.rdata = '0;
          s_next.rdata[ssp_pkg::STS_BUSY] = s_reg.busy;
        end
        ssp_pkg::HREG_RX: begin
          s_next.rdata = s_reg.rxw;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end

    // Data is frozen while a transfer runs
    if (WR && (ADDR == ssp_pkg::HREG_DATA) && !s_reg.busy) begin
      s_next.data = WDATA;
    end

    case (s_reg.st)
      ssp_pkg::HS_IDLE: begin
        // A mode change is only made here, with select high
        if (ctrl_go) begin
          s_next.st      = ssp_pkg::HS_LEAD;
          s_next.busy    = 1'h1;
          s_next.cs_n    = 1'h0;
          s_next.rd      = WDATA[ssp_pkg::CTL_READ];
          s_next.burst   = WDATA[ssp_pkg::CTL_BURST];
          s_next.three   = WDATA[ssp_pkg::CTL_3W];
          s_next.nlast   = WDATA[ssp_pkg::CTL_NB_LSB +: 2];
          s_next.raddr   =
            WDATA[ssp_pkg::CTL_ADDR_LSB +: ssp_pkg::ADDR_W];
          // Read flag, burst flag, then address MSB first
          s_next.tx      = {WDATA[ssp_pkg::CTL_READ],
                            WDATA[ssp_pkg::CTL_BURST],
                            WDATA[ssp_pkg::CTL_ADDR_LSB +: ssp_pkg::ADDR_W]};
          s_next.bitn    = '0;
          s_next.byten   = '0;
          s_next.cnt     = '0;
          s_next.mosi_oe = 1'h1;
        end
      end
      ssp_pkg::HS_LEAD: begin
        if (s_reg.cnt == ssp_pkg::HALF_LAST) begin
          s_next.cnt  = '0;
          s_next.st   = ssp_pkg::HS_LOW;
          s_next.sclk = 1'h0;
          s_next.mosi = s_reg.tx[ssp_pkg::BYTE_W-1];
          s_next.tx   = {s_reg.tx[ssp_pkg::BYTE_W-2:0], 1'h0};
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      ssp_pkg::HS_LOW: begin
        // Half period of two cycles keeps the clock at 5 MHz
        if (s_reg.cnt == ssp_pkg::HALF_LAST) begin
          s_next.cnt  = '0;
          s_next.st   = ssp_pkg::HS_HIGH;
          s_next.sclk = 1'h1;
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      ssp_pkg::HS_HIGH: begin
        if (s_reg.cnt == ssp_pkg::HALF_LAST) begin
          s_next.cnt = '0;
          s_next.rx  = rx_byte[ssp_pkg::BYTE_W-2:0];
          if (s_reg.bitn == ssp_pkg::BIT_LAST) begin
            // Received bytes of a write are dropped
            if (s_reg.byten != 3'h0 && s_reg.rd) begin
              s_next.rxw[{s_reg.byten[1:0] - 2'h1, 3'h0}
                         +: ssp_pkg::BYTE_W] = rx_byte;
            end
            if (s_reg.byten == ({1'h0, s_reg.nlast} + 3'h1)) begin
              s_next.st = ssp_pkg::HS_TAIL;
            end else begin
              s_next.byten   = s_reg.byten + 3'h1;
              s_next.bitn    = '0;
              s_next.st      = ssp_pkg::HS_LOW;
              s_next.sclk    = 1'h0;
              s_next.mosi    = nxt_byte[ssp_pkg::BYTE_W-1];
              s_next.tx      = {nxt_byte[ssp_pkg::BYTE_W-2:0], 1'h0};
              // Let go of the shared line for read data
              s_next.mosi_oe = !(s_reg.three && s_reg.rd);
            end
          end else begin
            s_next.bitn = s_reg.bitn + 3'h1;
            s_next.st   = ssp_pkg::HS_LOW;
            s_next.sclk = 1'h0;
            s_next.mosi = s_reg.tx[ssp_pkg::BYTE_W-1];
            s_next.tx   = {s_reg.tx[ssp_pkg::BYTE_W-2:0], 1'h0};
          end
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      ssp_pkg::HS_TAIL: begin
        // Clock rests high until select rises
        if (s_reg.cnt == ssp_pkg::HALF_LAST) begin
          s_next.cnt     = '0;
          s_next.st      = ssp_pkg::HS_GAP;
          s_next.cs_n    = 1'h1;
          s_next.mosi    = 1'h1;
          s_next.mosi_oe = 1'h1;
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      ssp_pkg::HS_GAP: begin
        if (s_reg.cnt == ssp_pkg::GAP_LAST) begin
          s_next.cnt  = '0;
          s_next.st   = ssp_pkg::HS_IDLE;
          s_next.busy = 1'h0;
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      default: begin
        s_next = RST;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s_reg <= RST;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA        = s_reg.rdata;
  assign BUSY         = s_reg.busy;
  assign link.cs_n    = s_reg.cs_n;
  assign link.sclk    = s_reg.sclk;
  assign link.mosi    = s_reg.mosi;
  assign link.mosi_oe = s_reg.mosi_oe;

endmodule : ssp_host
`default_nettype wire

// file: src/ssp_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_dev (
  input  wire logic                       SYS_CLK,
  input  wire logic                       SRST,
  input  wire logic                       CE,
  ssp_link_if.dev                         link,
  output var  logic                       TWO_WIRE_SEL,
  output var  logic                       THREE_WIRE,
  output var  logic                       WR_STB,
  output var  logic [ssp_pkg::ADDR_W-1:0] WR_ADDR,
  output var  logic [ssp_pkg::BYTE_W-1:0] WR_DATA
);

  // ****************************************
  // Link domain: frame, persistent, output
  // ****************************************
  typedef struct packed {
    logic                       phase;
    logic                       rw;
    logic                       burst;
    logic [2:0]                 bitn;
    logic [ssp_pkg::ADDR_W-1:0] addr;
    logic [ssp_pkg::BYTE_W-2:0] sh;
  } ssp_frame_t;

  typedef struct packed {
    logic [ssp_pkg::BYTE_W-1:0] fmt;
    logic                       wtgl;
    logic [ssp_pkg::ADDR_W-1:0] waddr;
    logic [ssp_pkg::BYTE_W-1:0] wdata;
  } ssp_keep_t;

  typedef struct packed {
    logic d;
    logic oe3;
    logic oe4;
  } ssp_out_t;

  typedef struct packed {
    logic                       lrst;
    logic                       wseen;
    logic                       two_wire;
    logic                       three;
    logic                       wr_stb;
    logic [ssp_pkg::ADDR_W-1:0] wr_addr;
    logic [ssp_pkg::BYTE_W-1:0] wr_data;
  } ssp_sys_t;

  localparam ssp_frame_t F_RST = '0;
  localparam ssp_keep_t  K_RST = '{fmt: ssp_pkg::FMT_RESET,
                                   wtgl: 1'h0, waddr: '0, wdata: '0};
  localparam ssp_out_t   O_RST = '0;
  localparam ssp_sys_t   Y_RST = '{lrst: 1'h1, wseen: 1'h0,
                                   two_wire: 1'h1, three: 1'h0,
                                   wr_stb: 1'h0, wr_addr: '0,
                                   wr_data: '0};

  ssp_frame_t f_reg, f_next;
  ssp_keep_t  k_reg, k_next;
  ssp_out_t   o_reg, o_next;
  ssp_sys_t   y_reg, y_next;
  logic [ssp_pkg::BYTE_W-1:0] mem [0:(1 << ssp_pkg::ADDR_W)-1];
  logic [ssp_pkg::BYTE_W-1:0] in_byte;
  logic [ssp_pkg::BYTE_W-1:0] rd_byte;
  logic                       mem_we;
  logic [2:0]                 sync_q;

  // Only listens: select and clock are inputs
  always_comb begin
    f_next  = f_reg;
    k_next  = k_reg;
    mem_we  = 1'h0;
    in_byte = {f_reg.sh, link.sdio};
    f_next.sh   = in_byte[ssp_pkg::BYTE_W-2:0];
    f_next.bitn = f_reg.bitn + 3'h1;
    if (f_reg.bitn == ssp_pkg::BIT_LAST) begin
      if (!f_reg.phase) begin
        f_next.phase = 1'h1;
        f_next.rw    = in_byte[ssp_pkg::CMD_RW_BIT];
        f_next.burst = in_byte[ssp_pkg::CMD_BURST_BIT];
        f_next.addr  = in_byte[ssp_pkg::ADDR_W-1:0];
      end else begin
        // Any register may be written at any time
        if (!f_reg.rw) begin
          mem_we       = 1'h1;
          k_next.wtgl  = ~k_reg.wtgl;
          k_next.waddr = f_reg.addr;
          k_next.wdata = in_byte;
          if (f_reg.addr == ssp_pkg::OFS_OUTPUT_FORMAT) begin
            k_next.fmt = in_byte;
          end
        end
        if (f_reg.burst) begin
          f_next.addr = f_reg.addr + 6'h01;
        end
      end
    end
  end

  // Frame state starts clean on every select assertion
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      f_reg <= F_RST;
    end else begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge link.sclk or posedge y_reg.lrst) begin
    if (y_reg.lrst) begin
      k_reg <= K_RST;
    end else begin
      k_reg <= k_next;
    end
  end

  // Array has no reset; unwritten registers other than the output format read undefined
  always_ff @(posedge link.sclk) begin
    if (mem_we) begin
      mem[f_reg.addr] <= in_byte;
    end
  end

  // Reads return the last stored value, no sample pacing
  always_comb begin
    rd_byte = (f_reg.addr == ssp_pkg::OFS_OUTPUT_FORMAT) ? k_reg.fmt
                                                         : mem[f_reg.addr];
    o_next.d   = rd_byte[~f_reg.bitn];
    // Drive only in the data phase of a read
    o_next.oe3 = f_reg.phase && f_reg.rw
                 && k_reg.fmt[ssp_pkg::FMT_WIRE_BIT];
    o_next.oe4 = f_reg.phase && f_reg.rw
                 && !k_reg.fmt[ssp_pkg::FMT_WIRE_BIT];
  end

  // Output moves on the falling edge
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      o_reg <= O_RST;
    end else begin
      o_reg <= o_next;
    end
  end

  assign link.sdo     = o_reg.d;
  assign link.sdo_oe  = o_reg.oe4;
  assign link.sdio_d  = o_reg.d;
  assign link.sdio_oe = o_reg.oe3;

  // ****************************************
  // System domain
  // ****************************************
  ssp_sync #(
    .W (3)
  ) u_sync (
    .clk (SYS_CLK),
    .ce  (CE),
    .d   ({k_reg.wtgl, link.cs_n, k_reg.fmt[ssp_pkg::FMT_WIRE_BIT]}),
    .q   (sync_q)
  );

  always_comb begin
    y_next        = y_reg;
    y_next.lrst   = 1'h0;
    y_next.wr_stb = 1'h0;
    y_next.three  = sync_q[0];
    // Two-wire holds until select is ever seen low
    if (!sync_q[1]) begin
      y_next.two_wire = 1'h0;
    end
    // Word is stable for a whole byte time after the toggle
    if (sync_q[2] != y_reg.wseen) begin
      y_next.wseen   = sync_q[2];
      y_next.wr_stb  = 1'h1;
      y_next.wr_addr = k_reg.waddr;
      y_next.wr_data = k_reg.wdata;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      y_reg <= Y_RST;
    end else if (CE) begin
      y_reg <= y_next;
    end
  end

  assign TWO_WIRE_SEL = y_reg.two_wire;
  assign THREE_WIRE   = y_reg.three;
  assign WR_STB       = y_reg.wr_stb;
  assign WR_ADDR      = y_reg.wr_addr;
  assign WR_DATA      = y_reg.wr_data;

endmodule : ssp_dev
`default_nettype wire

// file: verification/ssp_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_link_asserts (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic mosi_oe,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdio_d,
  input wire logic sdio_oe
);
  // ********
  // Link rules seen at SYS_CLK
  // ********
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  wire logic dev_oe = sdo_oe | sdio_oe;

  a_idle_high: assert property (cs_n |-> sclk)
    else $error("serial clock low outside a frame");
  a_cs_on_high: assert property ($changed(cs_n)
    |-> sclk && $past(sclk))
    else $error("select moved while serial clock low");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select high for under three cycles");
  a_low_min: assert property ($fell(sclk) |=> !sclk)
    else $error("serial clock low half too short");
  a_high_min: assert property ($rose(sclk) && !cs_n |=> sclk)
    else $error("serial clock high half too short");
  a_mosi_fall: assert property ($changed(mosi) && mosi_oe && !cs_n
    && !$past(cs_n) |-> !sclk)
    else $error("host data moved while clock high");
  a_sdo_fall: assert property ($changed(sdo) && $past(sdo_oe)
    && sdo_oe |-> !sclk)
    else $error("device data moved while clock high");
  a_dev_in_frame: assert property (dev_oe |-> !cs_n)
    else $error("device drives outside a frame");
  a_oe_on_fall: assert property ($rose(dev_oe) |-> !sclk)
    else $error("device output enabled off a falling edge");
  a_no_fight: assert property (sdio_oe |-> !mosi_oe)
    else $error("both ends drive the shared line");
  a_cmd_quiet: assert property ($fell(cs_n) |-> !dev_oe
    throughout (##30 1'h1))
    else $error("device drives during command byte");
endmodule : ssp_link_asserts
`default_nettype wire

// file: verification/sensor_spi_slave_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_spi_slave_port_tb;
  // ********
  // Harness
  // ********
  logic                       clk   = 1'h0;
  logic                       srst  = 1'h1;
  logic                       ce    = 1'h1;
  logic [ssp_pkg::REG_AW-1:0] addr  = 4'h0;
  logic [ssp_pkg::REG_DW-1:0] wdata = 32'h0000_0000;
  logic                       wr    = 1'h0;
  logic                       rd    = 1'h0;
  logic [ssp_pkg::REG_DW-1:0] rdata;
  logic                       busy;
  logic                       two_wire;
  logic                       three_wire;
  logic                       wr_stb;
  logic [ssp_pkg::ADDR_W-1:0] wr_addr;
  logic [ssp_pkg::BYTE_W-1:0] wr_data;
  int                         errors = 0;
  int                         check_count = 0;
  logic [13:0]                wq[$];

  always #25 clk = ~clk;

  ssp_link_if link ();
  ssp_host u_ssp_host (.SYS_CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy),
    .link(link));
  ssp_dev u_ssp_dev (.SYS_CLK(clk), .SRST(srst), .CE(ce), .link(link),
    .TWO_WIRE_SEL(two_wire), .THREE_WIRE(three_wire), .WR_STB(wr_stb),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  ssp_link_asserts u_ssp_link_asserts (.SYS_CLK(clk), .SRST(srst),
    .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
    .mosi_oe(link.mosi_oe), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
    .sdio_d(link.sdio_d), .sdio_oe(link.sdio_oe));

  // Every device-side write is logged; sampled away from the launch edge
  always @(negedge clk) begin
    if (wr_stb === 1'h1) begin
      wq.push_back({wr_addr, wr_data});
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    // Read data stands only in this cycle; taken mid-cycle
    @(negedge clk);
    d = rdata;
  endtask : bus_rd

  // Mode bits are {three wire, burst, read}
  task automatic xfer(input logic [5:0] a, input logic [2:0] md,
                      input logic [1:0] nm1, input logic [31:0] d,
                      output logic [31:0] rx);
    logic [31:0] s;
    bus_wr(ssp_pkg::HREG_DATA, d);
    bus_wr(ssp_pkg::HREG_CTRL, {18'h0_0000, a, 2'h0, nm1, md, 1'h1});
    for (int i = 0; i < 200; i++) begin
      bus_rd(ssp_pkg::HREG_STATUS, s);
      if (s[ssp_pkg::STS_BUSY] === 1'h0) break;
      if (i == 199) begin
        errors++;
        end_sim();
      end
    end
    check("link idle", 32'({link.cs_n, link.sclk}), 32'h3);
    check("busy pin", 32'(busy), 32'h0);
    bus_rd(ssp_pkg::HREG_RX, rx);
  endtask : xfer

  task automatic chk_wr(input logic [5:0] a, input logic [7:0] d);
    logic [13:0] e;
    e = (wq.size() > 0) ? wq.pop_front() : 14'h3FFF;
    check("write", 32'(e), 32'({a, d}));
  endtask : chk_wr

  task automatic wait_mode(input logic e);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (three_wire === e) break;
    end
    check("three wire", 32'(three_wire), 32'(e));
  endtask : wait_mode

  // ********
  // Scenarios
  // ********
  initial begin
    logic [31:0] v;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    repeat (3) @(posedge clk);
    check("two wire", 32'(two_wire), 32'h1);
    check("three wire", 32'(three_wire), 32'h0);
    bus_rd(4'h2, v);
    check("unmapped", v, 32'h0000_0000);
    // Burst write wraps past the top address
    xfer(6'h3E, 3'h2, 2'h3, 32'h8877_6655, v);
    for (int k = 0; k < 4; k++) begin
      chk_wr(6'(6'h3E + k), 8'(8'h55 + 8'h11 * k));
    end
    check("two wire", 32'(two_wire), 32'h0);
    xfer(6'h3E, 3'h3, 2'h3, 32'h0000_0000, v);
    check("burst read", v, 32'h8877_6655);
    // Without the burst flag the pointer holds
    xfer(6'h05, 3'h0, 2'h1, 32'h0000_B2A1, v);
    chk_wr(6'h05, 8'hA1);
    chk_wr(6'h05, 8'hB2);
    xfer(6'h05, 3'h1, 2'h0, 32'h0000_0000, v);
    check("single read", 32'(v[7:0]), 32'h0000_00B2);
    // Switch to the shared data line and back
    xfer(ssp_pkg::OFS_OUTPUT_FORMAT, 3'h0, 2'h0, 32'h0000_0040, v);
    chk_wr(ssp_pkg::OFS_OUTPUT_FORMAT, 8'h40);
    wait_mode(1'h1);
    xfer(6'h3E, 3'h7, 2'h1, 32'h0000_0000, v);
    check("3w burst", 32'(v[15:0]), 32'h0000_6655);
    xfer(ssp_pkg::OFS_OUTPUT_FORMAT, 3'h5, 2'h0, 32'h0000_0000, v);
    check("format", 32'(v[7:0]), 32'h0000_0040);
    xfer(ssp_pkg::OFS_OUTPUT_FORMAT, 3'h4, 2'h0, 32'h0000_0000, v);
    chk_wr(ssp_pkg::OFS_OUTPUT_FORMAT, 8'h00);
    wait_mode(1'h0);
    bus_rd(ssp_pkg::HREG_CTRL, v);
    check("ctrl", v, 32'h0000_3108);
    check("extra writes", 32'(wq.size()), 32'h0);
    end_sim();
  end
endmodule : sensor_spi_slave_port_tb
`default_nettype wire
